// File: hw/monitor_alert_status_mask.sv
// status flags, mask, configuration bits and alert output of the monitor
`timescale 1ns/1ps
//
// Overview of operation
// R1 - low alert input pin sets status A bit 7
// R2 - voltage channel out of range sets bits 0-6
// R3 - overtemp crossing sets status B bit 5
// R4 - chassis intrusion pin high sets B bit 4
// R5 - fan limits set B bits 2 and 3
// R6 - board temp input event sets B bit 1
// R7 - temperature limit crossing sets B bit 0
// R8 - status registers read-only, zero reset, B[7:6] zero
// R9 - mask register at 0x03, reset zero
// R10 - set mask bit removes flag from alert
// R11 - alert driven when enabled; bit 2 polarity
// R12 - config bit 3 pauses monitoring and alert
// R13 - alert is OR of unmasked status A flags
// R14 - flags clear on read, re-set if persisting
module monitor_alert_status_mask (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input alert_pkg::reg_req_s i_reg_req,
   input alert_pkg::monitor_events_s i_events,
   input wire logic i_temp_event_mode,
   input wire logic i_overtemp_event_mode,
   input wire logic i_alert_in_n,
   input wire logic i_chassis_intrusion_input,
   input wire logic i_board_temp_input_n,
   output logic [7:0] o_reg_rdata,
   output logic o_alert,
   output logic o_alert_oe,
   output logic o_monitor_pause
);
   typedef struct packed {
      logic [2:0] sync_a;
      logic [2:0] sync_b;
      logic [2:0] cfg;
      logic [7:0] mask_a;
      logic temp_prev;
      logic overtemp_prev;
      logic [7:0] rdata;
      logic alert;
      logic alert_oe;
      logic pause;
   } state_s;

   state_s state;
   state_s next_state;
   logic [alert_pkg::FLAG_COUNT-1:0] flag_set;
   logic [alert_pkg::FLAG_COUNT-1:0] flag_clear;
   logic [alert_pkg::FLAG_COUNT-1:0] flags;
   logic [7:0] status_a;
   logic [7:0] status_b;
   logic [7:0] cfg_value;
   logic alert_in_low;
   logic chassis_high;
   logic board_temp_low;
   logic monitoring;
   logic temp_set;
   logic overtemp_set;
   logic rd_a;
   logic rd_b;
   logic alert_active;

   // pins arrive asynchronously: sync_x[2:0] = {alert_in, chassis, board temp}
   assign alert_in_low = ~state.sync_b[2];
   assign chassis_high = state.sync_b[1];
   assign board_temp_low = ~state.sync_b[0];
   assign monitoring = ~state.pause; // R12

   // mode 1 catches the crossing edge, mode 0 follows the level
   assign temp_set = monitoring & (i_temp_event_mode ?
      (i_events.temp_limit_cross & ~state.temp_prev) : i_events.temp_limit_cross); // R7
   assign overtemp_set = monitoring & (i_overtemp_event_mode ?
      (i_events.overtemp_limit_cross & ~state.overtemp_prev) :
      i_events.overtemp_limit_cross); // R3

   always_comb begin
      flag_set = '0;
      flag_set[alert_pkg::VOLTAGE_CHANNELS-1:0] =
         i_events.voltage_out_of_range & {alert_pkg::VOLTAGE_CHANNELS{monitoring}}; // R2
      flag_set[alert_pkg::A_ALERT_IN_BIT] = alert_in_low; // R1
      flag_set[8 + alert_pkg::B_TEMP_BIT] = temp_set; // R7
      flag_set[8 + alert_pkg::B_BOARD_TEMP_BIT] = board_temp_low; // R6
      flag_set[8 + alert_pkg::B_FAN_ONE_BIT] = i_events.fan_speed_one_exceeded; // R5
      flag_set[8 + alert_pkg::B_FAN_TWO_BIT] = i_events.fan_speed_two_exceeded; // R5
      flag_set[8 + alert_pkg::B_CHASSIS_BIT] = chassis_high; // R4
      flag_set[8 + alert_pkg::B_OVERTEMP_BIT] = overtemp_set; // R3
   end

   assign rd_a = i_reg_req.rd && (i_reg_req.addr == alert_pkg::STATUS_A_OFFSET);
   assign rd_b = i_reg_req.rd && (i_reg_req.addr == alert_pkg::STATUS_B_OFFSET);
   assign flag_clear = {{alert_pkg::B_USED_BITS{rd_b}}, {8{rd_a}}}; // R14

   genvar gi;
   generate
      for (gi = 0; gi < alert_pkg::FLAG_COUNT; gi++) begin : g_flag
         flag_latch u_flag (
            .i_clk(i_clk),
            .i_reset_n(i_reset_n),
            .i_set(flag_set[gi]),
            .i_clear(flag_clear[gi]),
            .o_flag(flags[gi])
         );
      end
   endgenerate

   assign status_a = flags[7:0];
   assign status_b = {2'h0, flags[alert_pkg::FLAG_COUNT-1:8]}; // R8
   assign cfg_value = {4'h0, state.cfg, 1'b0};

   // unmasked flags of status A combined, then polarity applied
   assign alert_active = |(status_a & ~state.mask_a); // R10 R13

   always_comb begin
      next_state = state;
      next_state.sync_a = {i_alert_in_n, i_chassis_intrusion_input, i_board_temp_input_n};
      next_state.sync_b = state.sync_a;
      next_state.temp_prev = i_events.temp_limit_cross;
      next_state.overtemp_prev = i_events.overtemp_limit_cross;
      if (i_reg_req.wr) begin
         case (i_reg_req.addr)
            alert_pkg::CONFIG_OFFSET: begin
               next_state.cfg =
                  i_reg_req.wdata[alert_pkg::CFG_PAUSE_BIT:alert_pkg::CFG_ALERT_EN_BIT];
            end
            alert_pkg::MASK_A_OFFSET: begin
               next_state.mask_a = i_reg_req.wdata; // R9
            end
            default: begin
               next_state.mask_a = state.mask_a; // status registers ignore writes
            end
         endcase
      end
      if (i_reg_req.rd) begin
         case (i_reg_req.addr)
            alert_pkg::CONFIG_OFFSET: next_state.rdata = cfg_value;
            alert_pkg::STATUS_A_OFFSET: next_state.rdata = status_a; // R8
            alert_pkg::STATUS_B_OFFSET: next_state.rdata = status_b; // R8
            alert_pkg::MASK_A_OFFSET: next_state.rdata = state.mask_a;
            default: next_state.rdata = 8'h00;
         endcase
      end
      // new config acts on the outputs at the edge that writes it
      next_state.pause = next_state.cfg[alert_pkg::CFG_PAUSE_BIT-1]; // R12
      next_state.alert_oe = next_state.cfg[alert_pkg::CFG_ALERT_EN_BIT-1] &
         ~next_state.cfg[alert_pkg::CFG_PAUSE_BIT-1]; // R11 R12
      if (next_state.cfg[alert_pkg::CFG_POLARITY_BIT-1]) begin
         next_state.alert = next_state.alert_oe & alert_active; // R11
      end else begin
         next_state.alert = ~(next_state.alert_oe & alert_active); // R11
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         state <= '0;
         state.sync_a <= alert_pkg::PIN_SYNC_RESET;
         state.sync_b <= alert_pkg::PIN_SYNC_RESET;
         state.cfg <=
            alert_pkg::CONFIG_RESET[alert_pkg::CFG_PAUSE_BIT:alert_pkg::CFG_ALERT_EN_BIT];
         state.mask_a <= alert_pkg::MASK_A_RESET; // R9
         state.pause <= alert_pkg::CONFIG_RESET[alert_pkg::CFG_PAUSE_BIT];
         state.alert <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   assign o_reg_rdata = state.rdata;
   assign o_alert = state.alert;
   assign o_alert_oe = state.alert_oe;
   assign o_monitor_pause = state.pause;
endmodule : monitor_alert_status_mask

// File: inc/alert_pkg.sv
// constants and carrier types for the monitor alert status and mask logic
package alert_pkg;
   localparam logic [7:0] CONFIG_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_A_OFFSET = 8'h01;
   localparam logic [7:0] STATUS_B_OFFSET = 8'h02;
   localparam logic [7:0] MASK_A_OFFSET = 8'h03;

   localparam logic [7:0] STATUS_A_RESET = 8'h00;
   localparam logic [7:0] STATUS_B_RESET = 8'h00;
   localparam logic [7:0] MASK_A_RESET = 8'h00;
   localparam logic [7:0] CONFIG_RESET = 8'h08;
   // idle pin levels of {alert in, chassis, board temp}
   localparam logic [2:0] PIN_SYNC_RESET = 3'h5;

   localparam int CFG_ALERT_EN_BIT = 1;
   localparam int CFG_POLARITY_BIT = 2;
   localparam int CFG_PAUSE_BIT = 3;

   localparam int A_ALERT_IN_BIT = 7;
   localparam int B_TEMP_BIT = 0;
   localparam int B_BOARD_TEMP_BIT = 1;
   localparam int B_FAN_ONE_BIT = 2;
   localparam int B_FAN_TWO_BIT = 3;
   localparam int B_CHASSIS_BIT = 4;
   localparam int B_OVERTEMP_BIT = 5;
   localparam int B_USED_BITS = 6;

   localparam int VOLTAGE_CHANNELS = 7;
   localparam int FLAG_COUNT = 8 + B_USED_BITS;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   typedef struct packed {
      logic [VOLTAGE_CHANNELS-1:0] voltage_out_of_range;
      logic temp_limit_cross;
      logic overtemp_limit_cross;
      logic fan_speed_one_exceeded;
      logic fan_speed_two_exceeded;
   } monitor_events_s;

   typedef struct packed {
      logic flag;
   } flag_state_s;
endpackage : alert_pkg

// File: hw/flag_latch.sv
// one sticky status flag: set wins over clear
`timescale 1ns/1ps
module flag_latch (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_set,
   input wire logic i_clear,
   output logic o_flag
);
   alert_pkg::flag_state_s state;
   alert_pkg::flag_state_s next_state;

   always_comb begin
      next_state = state;
      if (i_set) begin
         next_state.flag = 1'b1;
      end else if (i_clear) begin
         next_state.flag = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign o_flag = state.flag;
endmodule : flag_latch

// File: tb/monitor_alert_props.sv
// port checker of the alert status and mask block
`timescale 1ns/1ps
module monitor_alert_props (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input alert_pkg::reg_req_s i_reg_req,
   input alert_pkg::monitor_events_s i_events,
   input wire logic i_alert_in_n,
   input wire logic [7:0] o_reg_rdata,
   input wire logic o_alert_oe,
   input wire logic o_monitor_pause
);
   logic [2:0] calm;
   logic [2:0] next_calm;
   logic cfg_wr;
   logic rd_a;
   assign cfg_wr = i_reg_req.wr && i_reg_req.addr == 8'h00;
   assign rd_a = i_reg_req.rd && i_reg_req.addr == 8'h01;
   // cycles with no voltage event and alert pin idle
   always_comb begin
      next_calm = calm;
      if (i_events.voltage_out_of_range != 7'h00 || !i_alert_in_n) next_calm = 3'h0;
      else if (calm != 3'h7) next_calm = calm + 3'h1;
   end
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) calm <= 3'h0;
      else calm <= next_calm;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   pause_write_a: assert property (
      cfg_wr |=> o_monitor_pause == $past(i_reg_req.wdata[3])) else $error("pause bad");
   oe_write_a: assert property (
      cfg_wr |=> o_alert_oe == ($past(i_reg_req.wdata[1]) && !$past(i_reg_req.wdata[3])))
      else $error("alert enable bad");
   unmapped_read_a: assert property (
      i_reg_req.rd && i_reg_req.addr > 8'h03 |=> o_reg_rdata == 8'h00) else $error("unmapped");
   reserved_zero_a: assert property (
      i_reg_req.rd && i_reg_req.addr == 8'h02 |=> o_reg_rdata[7:6] == 2'b00) else $error("rsvd");
   rdata_hold_a: assert property (
      !i_reg_req.rd |=> $stable(o_reg_rdata)) else $error("read data moved");
   oe_hold_a: assert property (
      !o_alert_oe && !cfg_wr |=> !o_alert_oe) else $error("alert enabled unasked");
   pause_hold_a: assert property (
      !cfg_wr |=> $stable(o_monitor_pause)) else $error("pause moved");
   read_clear_a: assert property (
      rd_a ##3 (rd_a && calm >= 3'h6) |=> o_reg_rdata == 8'h00) else $error("flag not cleared");
endmodule : monitor_alert_props

// File: tb/reg_host.sv
// register host model driving the block's request port
`timescale 1ns/1ps
module reg_host (
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   output alert_pkg::reg_req_s o_req
);
   initial o_req = '0;
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
         output logic [7:0] rdata);
      @(posedge i_clk);
      o_req <= '{rd: !w, wr: w, addr: a, wdata: d};
      @(posedge i_clk);
      // released fields no longer show the last value
      o_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
      @(posedge i_clk);
      #1 rdata = i_rdata;
   endtask : access
endmodule : reg_host

// File: tb/tb_monitor_alert_status_mask.sv
// self-checking bench of the alert status and mask block
`timescale 1ns/1ps
module tb_monitor_alert_status_mask;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic alert_n = 1'b1, chassis = 1'b0, board_n = 1'b1, t_mode = 1'b0, ot_mode = 1'b0;
   alert_pkg::reg_req_s req;
   alert_pkg::monitor_events_s ev = '0;
   logic [7:0] rdata, got, m, v, cfg;
   logic alert, oe, pause;
   int n_fail = 0;
   int checks = 0;
   always #2.5 i_clk = ~i_clk;
   monitor_alert_status_mask dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_req(req),
      .i_events(ev), .i_temp_event_mode(t_mode), .i_overtemp_event_mode(ot_mode),
      .i_alert_in_n(alert_n), .i_chassis_intrusion_input(chassis),
      .i_board_temp_input_n(board_n), .o_reg_rdata(rdata), .o_alert(alert),
      .o_alert_oe(oe), .o_monitor_pause(pause));
   reg_host host (.i_clk(i_clk), .i_rdata(rdata), .o_req(req));
   function automatic logic [7:0] exp_alert(input logic [7:0] st, mk, cf);
      logic any;
      any = |(st & ~mk) & cf[1] & ~cf[3];
      return {7'h00, cf[2] ? any : ~any};
   endfunction : exp_alert
   task automatic cmp(input logic [7:0] exp, input logic [7:0] act);
      checks++;
      if (act !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t exp=%h act=%h", $time, exp, act);
      end
   endtask : cmp
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      host.access(1'b0, a, 8'h00, got);
      cmp(exp, got);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.access(1'b1, a, d, got);
   endtask : wr
   task automatic pulse(input alert_pkg::monitor_events_s e);
      @(posedge i_clk);
      ev <= e;
      @(posedge i_clk);
      ev <= '0;
      repeat (4) @(posedge i_clk);
      #1;
   endtask : pulse
   task automatic tally_and_finish;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      #100us;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(5603));
      repeat (10) @(posedge i_clk);
      i_reset_n <= 1'b1;
      rd(8'h00, 8'h08);
      rd(8'h01, 8'h00);
      rd(8'h02, 8'h00);
      rd(8'h03, 8'h00);
      rd(8'h10, 8'h00);
      cmp(8'h00, {7'h00, oe});
      m = 8'($urandom);
      wr(8'h03, m);
      rd(8'h03, m);
      wr(8'h01, 8'hFF);
      rd(8'h01, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 10; i++) begin
         v = (i < 2) ? 8'h7F : {1'b0, 7'($urandom)};
         m = (i == 0) ? 8'h7F : 8'($urandom);
         cfg = i[0] ? 8'h02 : 8'h06;
         wr(8'h00, cfg);
         wr(8'h03, m);
         pulse('{v[6:0], 1'b0, 1'b0, 1'b0, 1'b0});
         cmp(exp_alert(v, m, cfg), {7'h00, alert});
         rd(8'h01, v);
         rd(8'h01, 8'h00);
         cmp(exp_alert(8'h00, m, cfg), {7'h00, alert});
      end
      $display("test voltage done");
      @(posedge i_clk);
      alert_n <= 1'b0;
      repeat (4) @(posedge i_clk);
      alert_n <= 1'b1;
      repeat (5) @(posedge i_clk);
      rd(8'h01, 8'h80);
      @(posedge i_clk);
      chassis <= 1'b1;
      board_n <= 1'b0;
      pulse('{7'h00, 1'b1, 1'b1, 1'b1, 1'b1});
      @(posedge i_clk);
      chassis <= 1'b0;
      board_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      rd(8'h02, 8'h3F);
      rd(8'h02, 8'h00);
      @(posedge i_clk);
      t_mode <= 1'b1;
      ot_mode <= 1'b1;
      ev.temp_limit_cross <= 1'b1;
      ev.overtemp_limit_cross <= 1'b1;
      repeat (3) @(posedge i_clk);
      rd(8'h02, 8'h21);
      rd(8'h02, 8'h00);
      $display("test pins done");
      @(posedge i_clk);
      ev <= '0;
      pulse('{7'h01, 1'b0, 1'b0, 1'b0, 1'b0});
      wr(8'h00, 8'h0E);
      cmp(8'h01, {7'h00, pause});
      cmp(8'h00, {7'h00, oe});
      cmp(exp_alert(8'h01, m, 8'h0E), {7'h00, alert});
      rd(8'h01, 8'h01);
      pulse('{7'h7F, 1'b0, 1'b0, 1'b0, 1'b0});
      rd(8'h01, 8'h00);
      wr(8'h00, 8'h06);
      cmp(8'h01, {7'h00, oe});
      $display("test pause done");
      tally_and_finish();
   end
endmodule : tb_monitor_alert_status_mask
bind monitor_alert_status_mask monitor_alert_props chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
   .i_reg_req(i_reg_req), .i_events(i_events), .i_alert_in_n(i_alert_in_n),
   .o_reg_rdata(o_reg_rdata), .o_alert_oe(o_alert_oe), .o_monitor_pause(o_monitor_pause));
